// ==== irq_core_model.sv ====
// core model: takes offered vectors and acknowledges after a lag
`timescale 1ns/1ps
module irq_core_model (
    input  wire logic        clock,      // system clock
    input  wire logic        rst,        // sync reset, high
    input  wire logic [7:0]  lag,        // cycles before acknowledge
    input  wire logic        irq_req,    // offer from controller
    input  wire logic [15:0] irq_vector, // offered vector
    output logic             cpu_ack,    // one-cycle acknowledge
    output logic [15:0]      taken_vec,  // last vector taken
    output int               n_taken     // acknowledges so far
);
    logic [7:0] wait_reg;

    // a withdrawn offer restarts the lag, so no stale acknowledge
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_reg  <= 8'h00;
            cpu_ack   <= 1'b0;
            taken_vec <= 16'h0000;
            n_taken   <= 0;
        end else if (!irq_req) begin
            wait_reg <= 8'h00;
            cpu_ack  <= 1'b0;
        end else if (cpu_ack) begin
            taken_vec <= irq_vector;
            n_taken   <= n_taken + 1;
            cpu_ack   <= 1'b0;
            wait_reg  <= 8'h00;
        end else if (wait_reg >= lag) begin
            cpu_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 8'h01;
        end
    end
endmodule

// ==== irq_ctrl.sv ====
// vectored priority interrupt controller with three programmable levels
// Functional notes
// - twenty four sources, each with own vector
// - vector entries two bytes, high byte even
// - reset entry at 0002h, never a source
// - watchdog 0004h, trap 0006h, peripherals follow
// - eight shared port edges at 0018h-0026h
// - timer3, serial1 rx/tx, DMA at 0028h-002Eh
// - four dual-edge sources lowest, 0030h-0036h
// - global enable set by enable, return, write
// - global enable cleared by disable, ack, traps
// - level three beats two beats one
// - same level: lower vector address wins
// - reset, watchdog, trap beat programmable levels
// - sources pulse for exactly one cycle
// - pulse sets pending bit until cleared
// - acknowledge clears the served pending bit
// - writing zero clears a pending bit
// - writing one raises a software request
// - forward winner only while globally enabled
// - polled mode: pending bits still readable
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int NSRC = 24
) (
    input  wire logic            clock,          // system clock
    input  wire logic            rst,            // sync reset, high
    input  wire logic [NSRC-1:0] src_pulse,      // one-cycle requests
    input  wire logic            wdt_event,      // watchdog pulse
    input  wire logic            trap_instr,     // trap instruction
    input  wire logic            illegal_trap,   // illegal opcode trap
    input  wire logic            enable_interrupts_instr,  // enable instr
    input  wire logic            disable_interrupts_instr, // disable instr
    input  wire logic            interrupt_return_instr,   // return instr
    input  wire logic            cpu_ack,        // core takes offer
    output logic                 irq_req,        // request to core
    output logic [15:0]          irq_vector,     // vector address
    output logic [4:0]           irq_source,     // winning source index
    output logic                 irq_exception,  // offer is wdt/trap
    input  wire logic [3:0]      reg_addr,       // register address
    input  wire logic [7:0]      reg_wdata,      // write data
    input  wire logic            reg_wr,         // write strobe
    input  wire logic            reg_rd,         // read strobe
    output logic [7:0]           reg_rdata       // read data, next cycle
);
    initial begin
        if (NSRC != 24) begin
            $error("irq_ctrl: vector table serves exactly 24 sources");
        end
    end

    logic [NSRC-1:0]   pend_reg;
    logic [NSRC-1:0]   ena_reg;
    logic [2*NSRC-1:0] pri_reg;
    logic              global_irq_enable_bit;
    logic              wdt_ie_reg;
    logic              wdt_pend_reg;
    logic              trap_pend_reg;
    deliver_state_e    state_reg;

    // one flat index per source in vector-table order: 0 is timer 2
    // (0008h), 23 is port C0 (0036h)
    logic [NSRC-1:0] sw_wr_mask;
    logic [NSRC-1:0] sw_wr_val;
    logic [NSRC-1:0] ack_clr;

    always_comb begin
        sw_wr_mask = '0;
        sw_wr_val  = '0;
        if (reg_wr && reg_addr == `REQ_LO_OFS) begin
            sw_wr_mask[7:0]  = 8'hFF;
            sw_wr_val[7:0]   = reg_wdata;
        end else if (reg_wr && reg_addr == `REQ_MID_OFS) begin
            sw_wr_mask[15:8] = 8'hFF;
            sw_wr_val[15:8]  = reg_wdata;
        end else if (reg_wr && reg_addr == `REQ_HI_OFS) begin
            sw_wr_mask[23:16] = 8'hFF;
            sw_wr_val[23:16]  = reg_wdata;
        end
    end

    // pending bits: atomic AND/OR from the core arrive as one write here,
    // so a request can only be lost if software writes a stale copy
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_reg <= `REQ_RESET;
        end else begin
            pend_reg <= ((pend_reg & ~sw_wr_mask)
                         | (sw_wr_val & sw_wr_mask))
                        & ~ack_clr
                        | src_pulse;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ena_reg <= `ENA_RESET;
        end else if (reg_wr && reg_addr == `ENA_LO_OFS) begin
            ena_reg[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == `ENA_MID_OFS) begin
            ena_reg[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == `ENA_HI_OFS) begin
            ena_reg[23:16] <= reg_wdata;
        end
    end

    // six priority bytes, four 2-bit fields each
    always_ff @(posedge clock) begin
        if (rst) begin
            pri_reg <= `PRI_RESET;
        end else begin
            for (int b = 0; b < 6; b++) begin
                if (reg_wr && reg_addr == 4'(`PRI_BASE_OFS + b)) begin
                    pri_reg[b*8 +: 8] <= reg_wdata;
                end
            end
        end
    end

    logic offer_taken;
    assign offer_taken = (state_reg == ST_OFFER) && cpu_ack;

    // clears come first so the disabling events dominate
    always_ff @(posedge clock) begin
        if (rst) begin
            global_irq_enable_bit <= 1'b0;
        end else if (disable_interrupts_instr || offer_taken
                     || trap_instr || illegal_trap) begin
            global_irq_enable_bit <= 1'b0;
        end else if (reg_wr && reg_addr == `CTRL_OFS) begin
            global_irq_enable_bit <= reg_wdata[`CTRL_GIE_BIT];
        end else if (enable_interrupts_instr
                     || interrupt_return_instr) begin
            global_irq_enable_bit <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wdt_ie_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `CTRL_OFS) begin
            wdt_ie_reg <= reg_wdata[`CTRL_WDT_IE_BIT];
        end
    end

    logic ack_wdt;
    logic ack_trap;

    // watchdog interrupt latched only when configured to interrupt
    always_ff @(posedge clock) begin
        if (rst) begin
            wdt_pend_reg <= 1'b0;
        end else if (wdt_event && wdt_ie_reg) begin
            wdt_pend_reg <= 1'b1;
        end else if (ack_wdt) begin
            wdt_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            trap_pend_reg <= 1'b0;
        end else if (illegal_trap) begin
            trap_pend_reg <= 1'b1;
        end else if (ack_trap) begin
            trap_pend_reg <= 1'b0;
        end
    end

    // per-level candidates; disabled sources latch but never compete
    logic [NSRC-1:0] cand [1:3];
    logic [3:1]      lvl_found;
    logic [4:0]      lvl_index [1:3];

    always_comb begin
        for (int l = 1; l <= 3; l++) begin
            for (int i = 0; i < NSRC; i++) begin
                cand[l][i] = pend_reg[i] && ena_reg[i]
                             && (pri_reg[i*2 +: 2] == 2'(l));
            end
        end
    end

    genvar g;
    generate
        for (g = 1; g <= 3; g++) begin : g_lvl
            prio_level_pick #(
                .N     (NSRC)
            ) u_pick (
                .cand  (cand[g]),
                .found (lvl_found[g]),
                .index (lvl_index[g])
            );
        end
    endgenerate

    logic        win_valid;
    logic        win_exc;
    logic [4:0]  win_index;
    vector_t     win_vector;

    always_comb begin
        win_valid  = 1'b1;
        win_exc    = 1'b1;
        win_index  = 5'h00;
        win_vector = `VEC_FIRST_SRC;
        if (wdt_pend_reg) begin
            win_vector = `VEC_WDT;
        end else if (trap_pend_reg) begin
            win_vector = `VEC_TRAP;
        end else begin
            win_exc = 1'b0;
            if (lvl_found[3]) begin
                win_index = lvl_index[3];
            end else if (lvl_found[2]) begin
                win_index = lvl_index[2];
            end else if (lvl_found[1]) begin
                win_index = lvl_index[1];
            end else begin
                win_valid = 1'b0;
            end
            // 2-byte entries from 0008h; 0002h reset is never offered
            win_vector = `VEC_FIRST_SRC
                         + 16'({win_index, 1'b0});
        end
    end

    // offer is latched so vector stays stable until the core acks
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (win_valid && global_irq_enable_bit) begin
                        state_reg <= ST_OFFER;
                    end
                end
                ST_OFFER: begin
                    if (cpu_ack) begin
                        state_reg <= ST_ACK;
                    end else if (!global_irq_enable_bit) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ACK: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_vector    <= `VEC_RESET;
            irq_source    <= 5'h00;
            irq_exception <= 1'b0;
        end else if (state_reg == ST_IDLE && win_valid) begin
            // reset entry stays visible until a first winner appears
            irq_vector    <= win_vector;
            irq_source    <= win_index;
            irq_exception <= win_exc;
        end
    end

    assign irq_req  = (state_reg == ST_OFFER);
    assign ack_wdt  = offer_taken && irq_exception
                      && irq_vector == `VEC_WDT;
    assign ack_trap = offer_taken && irq_exception
                      && irq_vector == `VEC_TRAP;

    always_comb begin
        ack_clr = '0;
        if (offer_taken && !irq_exception) begin
            ack_clr[irq_source] = 1'b1;
        end
    end

    // data reads zero without a read strobe; pending bits read in any mode
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `REQ_LO_OFS) begin
            reg_rdata <= pend_reg[7:0];
        end else if (reg_addr == `REQ_MID_OFS) begin
            reg_rdata <= pend_reg[15:8];
        end else if (reg_addr == `REQ_HI_OFS) begin
            reg_rdata <= pend_reg[23:16];
        end else if (reg_addr == `ENA_LO_OFS) begin
            reg_rdata <= ena_reg[7:0];
        end else if (reg_addr == `ENA_MID_OFS) begin
            reg_rdata <= ena_reg[15:8];
        end else if (reg_addr == `ENA_HI_OFS) begin
            reg_rdata <= ena_reg[23:16];
        end else if (reg_addr >= `PRI_BASE_OFS
                     && reg_addr < `CTRL_OFS) begin
            reg_rdata <= pri_reg[(int'(reg_addr) - 6)*8 +: 8];
        end else if (reg_addr == `CTRL_OFS) begin
            reg_rdata <= {6'h00, wdt_ie_reg, global_irq_enable_bit};
        end else if (reg_addr == `STATUS_OFS) begin
            reg_rdata <= {3'h0, irq_req, trap_pend_reg,
                          wdt_pend_reg, win_valid, 1'b0};
        end else if (reg_addr == `VEC_HI_OFS) begin
            reg_rdata <= irq_vector[15:8];
        end else begin
            reg_rdata <= irq_vector[7:0];
        end
    end

endmodule

// ==== irq_ctrl_chk.sv ====
// port-level assertions for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_chk #(
    parameter int NSRC = 24
) (
    input wire logic        clock,                    // system clock
    input wire logic        rst,                      // sync reset
    input wire logic        trap_instr,               // trap instruction
    input wire logic        illegal_trap,             // illegal opcode
    input wire logic        disable_interrupts_instr, // global off
    input wire logic        cpu_ack,                  // core acknowledge
    input wire logic        irq_req,                  // offer to core
    input wire logic [15:0] irq_vector,               // offered vector
    input wire logic [4:0]  irq_source,               // offered source
    input wire logic        irq_exception,            // wdt or trap offer
    input wire logic        reg_rd,                   // read strobe
    input wire logic [7:0]  reg_rdata                 // read data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_entry: assert property (
        $fell(rst) |-> irq_vector == 16'h0002 && !irq_req)
        else $error("vector not at reset entry after reset");
    a_vec_held: assert property (
        irq_req && $past(irq_req) |-> $stable(irq_vector))
        else $error("vector moved during an offer");
    a_ack_ends: assert property (
        irq_req && cpu_ack |=> !irq_req [*2])
        else $error("offer continued after acknowledge");
    a_off_drops: assert property (
        disable_interrupts_instr |=> ##1 !irq_req)
        else $error("offer kept after global disable");
    a_trap_quiet: assert property (
        trap_instr || illegal_trap |=> ##1 !irq_req)
        else $error("offer kept after a trap");
    a_vec_span: assert property (
        irq_req |-> !irq_vector[0]
            && irq_vector inside {[16'h0004:16'h0036]})
        else $error("offered vector outside the table");
    a_exc_vec: assert property (
        irq_req && irq_exception |-> irq_vector inside {16'h0004, 16'h0006})
        else $error("exception offer with wrong vector");
    a_src_vec: assert property (
        irq_req && !irq_exception |-> irq_source < NSRC
            && irq_vector == 16'h0008 + {10'h000, irq_source, 1'b0})
        else $error("source vector does not match source index");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");
endmodule

bind irq_ctrl irq_ctrl_chk #(.NSRC(NSRC)) u_irq_ctrl_chk (
    .clock(clock), .rst(rst), .trap_instr(trap_instr),
    .illegal_trap(illegal_trap),
    .disable_interrupts_instr(disable_interrupts_instr),
    .cpu_ack(cpu_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_source(irq_source), .irq_exception(irq_exception),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ==== irq_ctrl_map.svh ====
// register offsets, field positions, reset values and vector addresses
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// register offsets on the plain register port
`define REQ_LO_OFS      4'h0
`define REQ_MID_OFS     4'h1
`define REQ_HI_OFS      4'h2
`define ENA_LO_OFS      4'h3
`define ENA_MID_OFS     4'h4
`define ENA_HI_OFS      4'h5
`define PRI_BASE_OFS    4'h6
`define CTRL_OFS        4'hC
`define STATUS_OFS      4'hD
`define VEC_HI_OFS      4'hE
`define VEC_LO_OFS      4'hF

// control register fields
`define CTRL_GIE_BIT    0
`define CTRL_WDT_IE_BIT 1
`define CTRL_RESET      8'h00

`define REQ_RESET       24'h000000
`define ENA_RESET       24'h000000
`define PRI_RESET       48'h000000000000

// vector table
`define VEC_RESET       16'h0002
`define VEC_WDT         16'h0004
`define VEC_TRAP        16'h0006
`define VEC_FIRST_SRC   16'h0008
`define VEC_STEP        16'h0002

`endif

// ==== irq_ctrl_pkg.sv ====
// types shared by the interrupt controller files
package irq_ctrl_pkg;
    typedef logic [1:0]  prio_t;
    typedef logic [15:0] vector_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_OFFER = 3'b010,
        ST_ACK   = 3'b100
    } deliver_state_e;
endpackage

// ==== irq_ctrl_tb.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module irq_ctrl_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [23:0] src_pulse = 24'h000000;
    logic [5:0]  ev = 6'h00;
    logic [3:0]  reg_addr = 4'h0;
    logic [3:0]  byt;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  lag = 8'h00;
    logic [7:0]  reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        cpu_ack, irq_req, irq_exception;
    logic [15:0] irq_vector, taken_vec;
    logic [4:0]  irq_source;
    int          n_taken, n0, i, k;
    int          n_mismatch = 0;
    int          compares = 0;

    always #5 clock = ~clock;

    // ev: wdt, trap, illegal, enable, disable, return
    irq_ctrl #(.NSRC(24)) u_irq_ctrl (
        .clock(clock), .rst(rst), .src_pulse(src_pulse),
        .wdt_event(ev[5]), .trap_instr(ev[4]), .illegal_trap(ev[3]),
        .enable_interrupts_instr(ev[2]),
        .disable_interrupts_instr(ev[1]),
        .interrupt_return_instr(ev[0]), .cpu_ack(cpu_ack),
        .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_source(irq_source), .irq_exception(irq_exception),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    irq_core_model u_irq_core_model (
        .clock(clock), .rst(rst), .lag(lag), .irq_req(irq_req),
        .irq_vector(irq_vector), .cpu_ack(cpu_ack),
        .taken_vec(taken_vec), .n_taken(n_taken));

    task automatic wrap_up();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // full-byte write; also ends any pulse launched beside it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        src_pulse <= 24'h000000;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, reg_rdata});
        @(posedge clock);
    endtask
    task automatic fire(input logic [5:0] e, input logic [23:0] m);
        ev <= e;
        src_pulse <= m;
        @(posedge clock);
        ev <= 6'h00;
        src_pulse <= 24'h000000;
        @(posedge clock);
    endtask
    task automatic serve(input logic [15:0] v);
        n0 = n_taken;
        for (i = 0; i < 200 && n_taken == n0; i++) @(posedge clock);
        if (n_taken == n0) begin
            chk("ack wait", 16'h0001, 16'h0000);
            wrap_up();
        end else begin
            chk("vector", v, taken_vec);
        end
    endtask
    task automatic quiet();
        n0 = n_taken;
        repeat (20) @(posedge clock);
        chk("ack count", n0[15:0], n_taken[15:0]);
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (k = 0; k < 14; k++) rd(4'(k), 8'h00);
        rd(`VEC_HI_OFS, 8'h00);
        rd(`VEC_LO_OFS, 8'h02);
        for (k = 3; k < 12; k++) wr(4'(k), k < 6 ? 8'hFF : 8'h55);
        // polled: global enable still off
        fire(6'h00, 24'h420020);
        quiet();
        rd(`REQ_LO_OFS, 8'h20);
        rd(`REQ_MID_OFS, 8'h00);
        rd(`REQ_HI_OFS, 8'h42);
        src_pulse <= 24'h000008;
        wr(`REQ_LO_OFS, 8'h00);
        rd(`REQ_LO_OFS, 8'h08);
        wr(`REQ_LO_OFS, 8'h00);
        wr(`REQ_HI_OFS, 8'h00);
        for (k = 0; k < 24; k++) begin
            byt = `REQ_LO_OFS + 4'(k / 8);
            lag <= 8'(k % 3 * 4);
            wr(byt, 8'h01 << k[2:0]);
            wr(`CTRL_OFS, 8'h01);
            serve(`VEC_FIRST_SRC + 16'(2 * k));
            rd(byt, 8'h00);
            rd(`CTRL_OFS, 8'h00);
        end
        wr(`PRI_BASE_OFS + 4'h5, 8'hD5);
        wr(`PRI_BASE_OFS + 4'h3, 8'h56);
        fire(6'h00, 24'h801003);
        fire(6'h04, 24'h000000);
        serve(16'h0036);
        fire(6'h01, 24'h000000);
        serve(16'h0020);
        wr(`CTRL_OFS, 8'h01);
        serve(16'h0008);
        fire(6'h04, 24'h000000);
        serve(16'h000A);
        // watchdog events are dropped while its interrupt is off
        fire(6'h20, 24'h000000);
        rd(`STATUS_OFS, 8'h00);
        wr(`CTRL_OFS, 8'h02);
        wr(`ENA_LO_OFS, 8'hFB);
        fire(6'h28, 24'h000004);
        rd(`STATUS_OFS, 8'h0E);
        wr(`CTRL_OFS, 8'h03);
        serve(`VEC_WDT);
        wr(`CTRL_OFS, 8'h03);
        serve(`VEC_TRAP);
        wr(`CTRL_OFS, 8'h03);
        quiet();
        rd(`REQ_LO_OFS, 8'h04);
        fire(6'h10, 24'h000000);
        rd(`CTRL_OFS, 8'h02);
        // slow core, so the disable lands mid-offer
        lag <= 8'h28;
        wr(`ENA_LO_OFS, 8'hFF);
        wr(`CTRL_OFS, 8'h03);
        repeat (5) @(posedge clock);
        fire(6'h02, 24'h000000);
        quiet();
        rd(`REQ_LO_OFS, 8'h04);
        wr(`CTRL_OFS, 8'h01);
        repeat (3) @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`CTRL_OFS, 8'h00);
        rd(`REQ_LO_OFS, 8'h00);
        wrap_up();
    end
endmodule

// ==== prio_level_pick.sv ====
// lowest-index pending source among those at one priority level
`timescale 1ns/1ps
module prio_level_pick #(
    parameter int N = 24
) (
    input  wire logic [N-1:0]   cand,   // eligible requests at this level
    output logic                found,  // any candidate present
    output logic [4:0]          index   // lowest set index
);
    initial begin
        if (N < 1 || N > 32) begin
            $error("prio_level_pick: N out of range");
        end
    end

    always_comb begin
        found = 1'b0;
        index = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (cand[i]) begin
                found = 1'b1;
                index = 5'(i);
            end
        end
    end
endmodule
